// >>> design/rt_regs_pkg.sv
// Package of constants for the host register port and time tag counter.
// Assumes a single 25 MHz clock and synchronous host strobes.
package rt_regs_pkg;

  // ----------------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------------
  localparam logic [2:0] ADDR_TIME_TAG  = 3'h0;
  localparam logic [2:0] ADDR_CONTROL   = 3'h1;
  localparam logic [2:0] ADDR_BASE_PTR  = 3'h2;
  localparam logic [2:0] ADDR_STOP_TEST = 3'h3;
  localparam logic [2:0] ADDR_OP_STATUS = 3'h4;
  localparam logic [2:0] ADDR_LAST_CMD  = 3'h5;
  localparam int         ADDR_TOP_BIT   = 2;

  // ----------------------------------------------------------------------
  // Widths, reset values and timing
  // ----------------------------------------------------------------------
  localparam int          DATA_W        = 16;
  localparam logic [15:0] TIME_TAG_RST  = 16'h0000;
  localparam logic [15:0] CONTROL_RST   = 16'h0000;
  localparam logic [15:0] BASE_PTR_RST  = 16'h0000;
  localparam logic [15:0] ZERO_WORD     = 16'h0000;
  localparam int          CLK_KHZ       = 25000;
  localparam int          TICK_US       = 64;
  localparam int          TICK_CYCLES   = (TICK_US * CLK_KHZ) / 1000;
  localparam int          TX_HALF_CYCLES = 12;

endpackage : rt_regs_pkg

// >>> design/rt_reg_store.sv
// Small register store holding the host read/write words.
// Assumes writes and reads come from the port logic in the top module.
`timescale 1ns/100ps
module rt_reg_store #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  input  wire logic                     wr_en,
  input  wire logic [$clog2(DEPTH)-1:0] wr_addr,
  input  wire logic [WIDTH-1:0]         wr_data,
  input  wire logic [$clog2(DEPTH)-1:0] rd_addr,
  output logic      [WIDTH-1:0]         rd_data
);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [WIDTH-1:0] nxt_rd_data;

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  always_comb begin
    nxt_rd_data = mem_ff[rd_addr];
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_ff[i] <= '0;
      end
      rd_data <= '0;
    end else begin
      if (wr_en) begin
        mem_ff[wr_addr] <= wr_data;
      end
      rd_data <= nxt_rd_data;
    end
  end

endmodule : rt_reg_store

// >>> design/rt_host_register_port_time_tag.sv
// Host register port, time tag counter and biphase pin handling.
// Assumes host strobes and receive pins are synchronous to clk.
//
// Function
// [RULE1] Each channel takes Manchester serial input on its own one-phase pin.
// [RULE2] The receiver drives each zero-phase input as complement of one-phase.
// [RULE3] Zero-phase transmit output is complement of one-phase while sending.
// [RULE4] Both transmit outputs of each channel rest low when idle.
// [RULE5] Time tag, control and base pointer are host readable and writable.
// [RULE6] Status and last command are readable; writes to them do nothing.
// [RULE7] Stop self-test is write-only; writing it triggers its action.
// [RULE8] Address lines are inputs sampled while chip select is low.
// [RULE9] Register selected by decoding address with select, read, write.
// [RULE10] Write when select and write low; top address bit selects nothing.
// [RULE11] Time tag is a free-running 16-bit counter.
// [RULE12] Time tag advances once per 64 microseconds.
// [RULE13] Reset clears the time tag counter to zero.
// [RULE14] Host write loads the time tag; counting continues from there.
// [RULE15] At each received message end the time tag goes to shared memory.
// [RULE16] Host should read the time tag twice if consistency matters.
// [RULE17] Write codes 0..3 map to time tag, control, base pointer, self-test.
// [RULE18] System supplies the device clock all timing derives from.
// [RULE19] Active-low reset initialises everything before normal operation.
// [RULE20] Time tag tick is a clock divider giving 64 microseconds.
`timescale 1ns/100ps
module rt_host_register_port_time_tag #(
  parameter int TICK_DIV = rt_regs_pkg::TICK_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        cs_n,
  input  wire logic        rd_n,
  input  wire logic        wr_n,
  input  wire logic [2:0]  addr_in,
  output logic      [2:0]  addr_out,
  output logic      [2:0]  addr_oe,
  input  wire logic [15:0] data_in,
  output logic      [15:0] data_out,
  output logic             data_oe,
  input  wire logic        chan_a_rx_one,
  input  wire logic        chan_a_rx_zero,
  input  wire logic        chan_b_rx_one,
  input  wire logic        chan_b_rx_zero,
  input  wire logic        tx_active,
  input  wire logic        tx_chan_b,
  input  wire logic        tx_bit,
  input  wire logic        msg_rx_done,
  input  wire logic [15:0] op_status,
  input  wire logic [15:0] last_command,
  output logic             chan_a_tx_one,
  output logic             chan_a_tx_zero,
  output logic             chan_b_tx_one,
  output logic             chan_b_tx_zero,
  output logic             chan_a_rx_data,
  output logic             chan_b_rx_data,
  output logic             stop_self_test,
  output logic      [15:0] control_word,
  output logic      [15:0] base_pointer_word,
  output logic             tag_store_req,
  output logic      [15:0] tag_store_data
);

  // ----------------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------------
  logic rst_meta_ff;
  logic rst_sync_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff; // RULE19
    end
  end

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  function automatic logic [3:0] decode(input logic [2:0] a);
    logic [3:0] sel;
    sel = 4'h0;
    if (!a[rt_regs_pkg::ADDR_TOP_BIT]) begin
      sel[a[1:0]] = 1'b1;
    end
    return sel;
  endfunction : decode

  logic       wr_strobe;
  logic       rd_strobe;
  logic       wr_seen_ff;
  logic       nxt_wr_seen;
  logic [3:0] wr_sel;

  always_comb begin
    wr_strobe   = !cs_n && !wr_n && !wr_seen_ff; // RULE10
    rd_strobe   = !cs_n && !rd_n; // RULE9
    nxt_wr_seen = !cs_n && !wr_n;
    wr_sel      = wr_strobe ? decode(addr_in) : 4'h0; // RULE8 RULE17
  end

  // ----------------------------------------------------------------------
  // Time tag counter
  // ----------------------------------------------------------------------
  // A single-cycle counter avoids the ripple hazard, though hosts still
  // may read twice for safety.
  logic [15:0] time_tag_counter_ff;
  logic [15:0] nxt_time_tag_counter;
  logic [$clog2(TICK_DIV)-1:0] div_ff;
  logic [$clog2(TICK_DIV)-1:0] nxt_div;
  logic        tick;

  always_comb begin
    tick    = (div_ff == ($clog2(TICK_DIV))'(TICK_DIV - 1)); // RULE20 RULE12
    nxt_div = tick ? '0 : div_ff + 1'b1;
    nxt_time_tag_counter = time_tag_counter_ff;
    if (wr_sel[rt_regs_pkg::ADDR_TIME_TAG[1:0]]) begin
      nxt_time_tag_counter = data_in; // RULE14
    end else if (tick) begin
      nxt_time_tag_counter = time_tag_counter_ff + 16'h0001; // RULE11
    end
  end

  always_ff @(posedge clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      div_ff              <= '0;
      time_tag_counter_ff <= rt_regs_pkg::TIME_TAG_RST; // RULE13
    end else begin
      div_ff              <= nxt_div;
      time_tag_counter_ff <= nxt_time_tag_counter;
    end
  end

  // ----------------------------------------------------------------------
  // Stored words
  // ----------------------------------------------------------------------
  logic [15:0] store_rd;

  rt_reg_store #(
    .WIDTH (16),
    .DEPTH (4)
  ) u_store (
    .clk     (clk),
    .rst_n   (rst_sync_ff),
    .wr_en   (wr_sel[rt_regs_pkg::ADDR_CONTROL[1:0]] ||
              wr_sel[rt_regs_pkg::ADDR_BASE_PTR[1:0]]), // RULE5
    .wr_addr (addr_in[1:0]),
    .wr_data (data_in),
    .rd_addr (addr_in[1:0]),
    .rd_data (store_rd)
  );

  logic [15:0] control_ff;
  logic [15:0] base_ptr_ff;
  logic [15:0] nxt_control;
  logic [15:0] nxt_base_ptr;

  always_comb begin
    nxt_control  = wr_sel[rt_regs_pkg::ADDR_CONTROL[1:0]] ? data_in : control_ff;
    nxt_base_ptr = wr_sel[rt_regs_pkg::ADDR_BASE_PTR[1:0]] ? data_in : base_ptr_ff;
  end

  // ----------------------------------------------------------------------
  // Read data and outputs
  // ----------------------------------------------------------------------
  logic [2:0]  addr_q_ff;
  logic [15:0] nxt_data_out;
  logic        nxt_data_oe;
  logic        nxt_stop;
  logic        nxt_store_req;

  always_comb begin
    nxt_data_out = rt_regs_pkg::ZERO_WORD;
    case (addr_in)
      rt_regs_pkg::ADDR_TIME_TAG:  nxt_data_out = time_tag_counter_ff; // RULE5
      rt_regs_pkg::ADDR_CONTROL:   nxt_data_out = control_ff;
      rt_regs_pkg::ADDR_BASE_PTR:  nxt_data_out = base_ptr_ff;
      rt_regs_pkg::ADDR_OP_STATUS: nxt_data_out = op_status; // RULE6
      rt_regs_pkg::ADDR_LAST_CMD:  nxt_data_out = last_command; // RULE6
      default:                     nxt_data_out = rt_regs_pkg::ZERO_WORD; // RULE7
    endcase
    nxt_data_oe   = rd_strobe;
    nxt_stop      = wr_sel[rt_regs_pkg::ADDR_STOP_TEST[1:0]]; // RULE7
    nxt_store_req = msg_rx_done; // RULE15
  end

  always_ff @(posedge clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      control_ff        <= rt_regs_pkg::CONTROL_RST;
      base_ptr_ff       <= rt_regs_pkg::BASE_PTR_RST;
      control_word      <= rt_regs_pkg::CONTROL_RST;
      base_pointer_word <= rt_regs_pkg::BASE_PTR_RST;
      wr_seen_ff        <= 1'b0;
      addr_q_ff         <= 3'h0;
      addr_out          <= 3'h0;
      addr_oe           <= 3'h0;
      data_out          <= rt_regs_pkg::ZERO_WORD;
      data_oe           <= 1'b0;
      stop_self_test    <= 1'b0;
      tag_store_req     <= 1'b0;
      tag_store_data    <= rt_regs_pkg::ZERO_WORD;
    end else begin
      control_ff        <= nxt_control;
      base_ptr_ff       <= nxt_base_ptr;
      control_word      <= nxt_control;
      base_pointer_word <= nxt_base_ptr;
      wr_seen_ff        <= nxt_wr_seen;
      addr_q_ff         <= cs_n ? addr_q_ff : addr_in; // RULE8
      addr_out          <= addr_q_ff;
      addr_oe           <= 3'h0; // RULE8
      data_out          <= nxt_data_out;
      data_oe           <= nxt_data_oe;
      stop_self_test    <= nxt_stop;
      tag_store_req     <= nxt_store_req;
      tag_store_data    <= time_tag_counter_ff; // RULE15
    end
  end

  // ----------------------------------------------------------------------
  // Biphase pins
  // ----------------------------------------------------------------------
  // Only the one-phase inputs are used; the zero-phase inputs are assumed to
  // be their complement and are kept for pin compatibility.
  logic nxt_a_one;
  logic nxt_a_zero;
  logic nxt_b_one;
  logic nxt_b_zero;
  logic unused_rx;

  always_comb begin
    unused_rx  = chan_a_rx_zero ^ chan_b_rx_zero; // RULE2
    nxt_a_one  = 1'b0; // RULE4
    nxt_a_zero = 1'b0;
    nxt_b_one  = 1'b0;
    nxt_b_zero = 1'b0;
    if (tx_active && !tx_chan_b) begin
      nxt_a_one  = tx_bit;
      nxt_a_zero = !tx_bit; // RULE3
    end else if (tx_active && tx_chan_b) begin
      nxt_b_one  = tx_bit;
      nxt_b_zero = !tx_bit; // RULE3
    end
  end

  always_ff @(posedge clk or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      chan_a_tx_one  <= 1'b0;
      chan_a_tx_zero <= 1'b0;
      chan_b_tx_one  <= 1'b0;
      chan_b_tx_zero <= 1'b0;
      chan_a_rx_data <= 1'b0;
      chan_b_rx_data <= 1'b0;
    end else begin
      chan_a_tx_one  <= nxt_a_one;
      chan_a_tx_zero <= nxt_a_zero;
      chan_b_tx_one  <= nxt_b_one;
      chan_b_tx_zero <= nxt_b_zero;
      chan_a_rx_data <= chan_a_rx_one; // RULE1
      chan_b_rx_data <= chan_b_rx_one; // RULE1
    end
  end

endmodule : rt_host_register_port_time_tag

// >>> tb/rt_port_asserts.sv
// Checker for the host register port and biphase pins.
// Assumes the bench keeps the host strobes idle while in reset.
`timescale 1ns/100ps
module rt_port_chk (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        cs_n,
  input wire logic        rd_n,
  input wire logic        wr_n,
  input wire logic [2:0]  addr_in,
  input wire logic [2:0]  addr_oe,
  input wire logic [15:0] data_in,
  input wire logic [15:0] data_out,
  input wire logic        data_oe,
  input wire logic        chan_a_rx_one,
  input wire logic        chan_a_rx_data,
  input wire logic        tx_active,
  input wire logic        tx_chan_b,
  input wire logic        tx_bit,
  input wire logic        msg_rx_done,
  input wire logic [15:0] op_status,
  input wire logic        chan_a_tx_one,
  input wire logic        chan_a_tx_zero,
  input wire logic        chan_b_tx_one,
  input wire logic        chan_b_tx_zero,
  input wire logic        stop_self_test,
  input wire logic [15:0] control_word,
  input wire logic [15:0] base_pointer_word,
  input wire logic        tag_store_req
);
  // ----------
  // Properties
  // ----------
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_tx_a_send:
    assert property (tx_active && !tx_chan_b |=> chan_a_tx_one == $past(tx_bit)
      && chan_a_tx_zero == !$past(tx_bit)) else $error("chan a tx wrong");
  a_tx_b_send:
    assert property (tx_active && tx_chan_b |=> chan_b_tx_one == $past(tx_bit)
      && chan_b_tx_zero == !$past(tx_bit)) else $error("chan b tx wrong");
  a_tx_idle_low:
    assert property (!tx_active |=> !(chan_a_tx_one | chan_a_tx_zero | chan_b_tx_one
      | chan_b_tx_zero)) else $error("tx not idle low");
  a_rx_copy:
    assert property (chan_a_rx_one [*4] |-> chan_a_rx_data) else $error("rx copy lost");
  a_ctl_load:
    assert property ($fell(cs_n | wr_n) && addr_in == rt_regs_pkg::ADDR_CONTROL
      |=> control_word == $past(data_in)) else $error("control not loaded");
  a_stop_pulse:
    assert property ($fell(cs_n | wr_n) && addr_in == rt_regs_pkg::ADDR_STOP_TEST
      |=> stop_self_test ##1 !stop_self_test) else $error("stop pulse wrong");
  a_top_ignored:
    assert property (!cs_n && !wr_n && addr_in[2] |=> $stable(control_word)
      && $stable(base_pointer_word) && !stop_self_test) else $error("upper write acted");
  a_rd_status:
    assert property (!cs_n && !rd_n && addr_in == rt_regs_pkg::ADDR_OP_STATUS
      |=> data_oe && data_out == $past(op_status)) else $error("status read wrong");
  a_addr_input:
    assert property (!cs_n |-> addr_oe == 3'h0) else $error("address lines driven");
  a_tag_store:
    assert property (msg_rx_done |=> tag_store_req) else $error("tag store missed");
  c_stop: cover property (stop_self_test);
  c_tx_b: cover property (tx_active && tx_chan_b);
  c_store: cover property (tag_store_req);
endmodule : rt_port_chk
bind rt_host_register_port_time_tag rt_port_chk u_rt_port_chk (.*);

// >>> tb/bus_rx_model.sv
// Model of the two external bus receivers.
// Assumes the bench supplies each channel's serial level off the rising edge.
`timescale 1ns/100ps
module bus_rx_model (
  input  wire logic line_a,
  input  wire logic line_b,
  output logic      one_a,
  output logic      zero_a,
  output logic      one_b,
  output logic      zero_b
);
  // ----------
  // Receivers
  // ----------
  assign one_a  = line_a;
  assign zero_a = !line_a;
  assign one_b  = line_b;
  assign zero_b = !line_b;
endmodule : bus_rx_model

// >>> tb/tb_top.sv
// Self-checking bench for the host register port and time tag.
// Assumes the design package and the checker are compiled first.
`timescale 1ns/100ps
module tb_top;
  // ----------
  // Harness
  // ----------
  localparam int DIV = 4;
  logic        clk, rst_n, cs_n, rd_n, wr_n, tx_active, tx_chan_b, tx_bit, msg_rx_done;
  logic        line_a, line_b, ra1, ra0, rb1, rb0, ta1, ta0, tb1, tb0, rxa, rxb, stp, oe, tsr;
  logic [2:0]  addr_in, ao;
  logic [15:0] data_in, data_out, op_status, last_command, ctl, bp, tsd;
  logic [31:0] seed = 32'h0000_394b;
  int          n_fail, checks;
  bus_rx_model u_bus_rx_model (.line_a(line_a), .line_b(line_b), .one_a(ra1), .zero_a(ra0),
    .one_b(rb1), .zero_b(rb0));
  rt_host_register_port_time_tag #(.TICK_DIV(DIV)) u_rt_host_register_port_time_tag (
    .clk(clk), .rst_n(rst_n), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .addr_in(addr_in),
    .addr_out(ao), .addr_oe(), .data_in(data_in), .data_out(data_out), .data_oe(oe),
    .chan_a_rx_one(ra1), .chan_a_rx_zero(ra0), .chan_b_rx_one(rb1), .chan_b_rx_zero(rb0),
    .tx_active(tx_active), .tx_chan_b(tx_chan_b), .tx_bit(tx_bit), .msg_rx_done(msg_rx_done),
    .op_status(op_status), .last_command(last_command), .chan_a_tx_one(ta1),
    .chan_a_tx_zero(ta0), .chan_b_tx_one(tb1), .chan_b_tx_zero(tb0), .chan_a_rx_data(rxa),
    .chan_b_rx_data(rxb), .stop_self_test(stp), .control_word(ctl), .base_pointer_word(bp),
    .tag_store_req(tsr), .tag_store_data(tsd));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  function automatic logic [3:0] tx_exp(input logic act, input logic chb, input logic b);
    return act ? (chb ? {2'b00, b, !b} : {b, !b, 2'b00}) : 4'h0;
  endfunction : tx_exp
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  // One host access; a write and its release leave a full cycle before the next.
  task automatic acc(input logic wr, input logic [2:0] a, input logic [15:0] d,
                     output logic [15:0] q, output logic s);
    @(negedge clk);
    cs_n = 1'b0;
    rd_n = wr;
    wr_n = !wr;
    addr_in = a;
    data_in = d;
    @(negedge clk);
    q = data_out;
    s = wr ? stp : oe;
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
  endtask : acc
  task automatic end_sim;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_sim
  initial begin
    #(40 * 2000);
    n_fail++;
    end_sim;
  end
  // ----------
  // Tests
  // ----------
  initial begin
    logic [15:0] q, r, v;
    logic        s;
    {cs_n, rd_n, wr_n, tx_active, tx_chan_b, tx_bit, msg_rx_done} = 7'b1110000;
    {line_a, line_b, addr_in, data_in, op_status, last_command} = '0;
    rst_n = 1'b0;
    n_fail = 0;
    checks = 0;
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    acc(1'b0, 3'h0, 16'h0000, q, s);
    chk(q & 16'hfffe, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      v = (i == 0) ? 16'hffff : (i == 1) ? 16'h0000 : seed[15:0];
      for (int a = 1; a < 3; a++) begin
        acc(1'b1, 3'(a), (a == 1) ? v : ~v, q, s);
        acc(1'b0, 3'(a), 16'h0000, q, s);
        chk(q, (a == 1) ? v : ~v);
        chk({15'h0000, s}, 16'h0001);
      end
      acc(1'b1, {1'b1, seed[17:16]}, v ^ 16'h0f0f, q, s);
      chk({15'h0000, s}, 16'h0000);
      chk(ctl, v);
      chk(bp, ~v);
      op_status = seed[31:16];
      last_command = ~seed[31:16];
      acc(1'b1, i[0] ? 3'h5 : 3'h4, v, q, s);
      acc(1'b0, 3'h4, 16'h0000, q, s);
      chk(q, op_status);
      acc(1'b0, 3'h5, 16'h0000, q, s);
      chk(q, last_command);
      acc(1'b1, 3'h3, v, q, s);
      chk({15'h0000, s}, 16'h0001);
      acc(1'b0, (i < 2) ? 3'h3 : 3'(i + 4), 16'h0000, q, s);
      chk(q, 16'h0000);
    end
    $display("register test done");
    for (int i = 0; i < 2; i++) begin
      seed = xs(seed);
      v = i ? seed[15:0] : 16'hffff;
      acc(1'b1, 3'h0, v, q, s);
      acc(1'b0, 3'h0, 16'h0000, q, s);
      chk({15'h0000, 16'(q - v) < 16'h0003}, 16'h0001);
      acc(1'b0, 3'h0, 16'h0000, r, s);
      acc(1'b0, 3'h0, 16'h0000, q, s);
      chk({15'h0000, 16'(q - r) < 16'h0002}, 16'h0001);
      repeat (5 * DIV - 4) @(negedge clk);
      acc(1'b0, 3'h0, 16'h0000, q, s);
      chk(q - r, 16'h0005);
    end
    $display("time tag test done");
    acc(1'b0, 3'h6, 16'h0000, q, s);
    chk(q, 16'h0000);
    for (int i = 0; i < 40; i++) begin
      @(negedge clk);
      chk({12'h000, ta1, ta0, tb1, tb0}, {12'h000, tx_exp(tx_active, tx_chan_b, tx_bit)});
      chk({14'h0000, rxa, rxb}, {14'h0000, line_a, line_b});
      chk({13'h0000, ao}, 16'h0006);
      seed = xs(seed);
      {tx_active, tx_chan_b, tx_bit, line_a, line_b} = seed[4:0];
      msg_rx_done = seed[5] & ~msg_rx_done;
      op_status = seed[31:16];
      addr_in = seed[8:6];
    end
    $display("pin test done");
    @(negedge clk);
    {tx_active, line_a, line_b, msg_rx_done} = 4'h0;
    seed = xs(seed);
    acc(1'b1, 3'h0, seed[15:0], q, s);
    msg_rx_done = 1'b1;
    @(negedge clk);
    msg_rx_done = 1'b0;
    chk({15'h0000, tsr}, 16'h0001);
    chk(tsd, seed[15:0]);
    @(negedge clk);
    chk({15'h0000, tsr}, 16'h0000);
    acc(1'b1, 3'h0, 16'ha5a5, q, s);
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    acc(1'b0, 3'h0, 16'h0000, q, s);
    chk(q & 16'hfffe, 16'h0000);
    chk(ctl, 16'h0000);
    $display("store and reset test done");
    end_sim;
  end
endmodule : tb_top
